/* logic/fpag_pkg.sv */
// Constants, types and helpers for the flash program access gate
package fpag_pkg;

  // Link command codes
  localparam logic [7:0] FPAG_CMD_REV    = 8'h00;
  localparam logic [7:0] FPAG_CMD_STAT   = 8'h02;
  localparam logic [7:0] FPAG_CMD_WCTL   = 8'h04;
  localparam logic [7:0] FPAG_CMD_RCTL   = 8'h05;
  localparam logic [7:0] FPAG_CMD_WFC    = 8'h08;
  localparam logic [7:0] FPAG_CMD_WTEST  = 8'hF0;
  localparam logic [7:0] FPAG_TEST_BYPASS = 8'h04;

  // Flash command register values
  localparam logic [7:0] FPAG_FC_UNLOCK1 = 8'h73;
  localparam logic [7:0] FPAG_FC_UNLOCK2 = 8'h8C;
  localparam logic [7:0] FPAG_FC_SECSEL  = 8'h5E;
  localparam logic [7:0] FPAG_FC_PERASE  = 8'hB1; // Arbitrary code
  localparam logic [7:0] FPAG_FC_MERASE  = 8'hB2; // Arbitrary code
  localparam logic [7:0] FPAG_FC_LOCK    = 8'hB3; // Arbitrary code

  // Register file offsets in the flash bank
  localparam logic [7:0] FPAG_REG_FCMD   = 8'h01;
  localparam logic [7:0] FPAG_REG_PAGE   = 8'h02;

  // Status codes
  localparam logic [5:0] FPAG_ST_LOCKED   = 6'h00;
  localparam logic [5:0] FPAG_ST_UNLK1    = 6'h01;
  localparam logic [5:0] FPAG_ST_UNLK2    = 6'h02;
  localparam logic [5:0] FPAG_ST_UNLOCKED = 6'h03;
  localparam logic [5:0] FPAG_ST_SECSEL   = 6'h04;
  localparam logic [5:0] FPAG_ST_PROG     = 6'h08;
  localparam logic [5:0] FPAG_ST_PERASE   = 6'h10;
  localparam logic [5:0] FPAG_ST_MERASE   = 6'h20;

  // Field positions and widths
  localparam int         FPAG_ADDR_W     = 16;
  localparam int         FPAG_PAGE_HI    = 15;
  localparam int         FPAG_PAGE_LO    = 9;
  localparam int         FPAG_SEC_HI     = 15;
  localparam int         FPAG_SEC_LO     = 13;
  localparam int         FPAG_INFO_BIT   = 7;
  localparam int         FPAG_FCM_BIT    = 0;
  localparam logic [6:0] FPAG_INFO_OPEN  = 7'h03;
  localparam logic [8:0] FPAG_PAGE_BASE  = 9'h000;
  localparam logic [7:0] FPAG_RESET_BYTE = 8'h00;

  typedef enum logic [7:0] {
    FS_LOCKED   = 8'h01,
    FS_UNLK1    = 8'h02,
    FS_UNLK2    = 8'h04,
    FS_UNLOCKED = 8'h08,
    FS_SECSEL   = 8'h10,
    FS_PROG     = 8'h20,
    FS_PERASE   = 8'h40,
    FS_MERASE   = 8'h80
  } fpag_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] addr;
    logic [7:0] data;
  } fpag_cmd_t;

  typedef struct packed {
    logic                   prog;
    logic                   read;
    logic                   perase;
    logic                   merase;
    logic                   info;
    logic [FPAG_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
  } fpag_flash_t;

  // Status code of a controller state
  function automatic logic [5:0] fpag_status(fpag_state_t s);
    unique case (s)
      FS_LOCKED:   return FPAG_ST_LOCKED;
      FS_UNLK1:    return FPAG_ST_UNLK1;
      FS_UNLK2:    return FPAG_ST_UNLK2;
      FS_UNLOCKED: return FPAG_ST_UNLOCKED;
      FS_SECSEL:   return FPAG_ST_SECSEL;
      FS_PROG:     return FPAG_ST_PROG;
      FS_PERASE:   return FPAG_ST_PERASE;
      FS_MERASE:   return FPAG_ST_MERASE;
      default:     return FPAG_ST_LOCKED;
    endcase
  endfunction : fpag_status

  // Gate a flash access by the protect bits (1 means unprotected)
  function automatic fpag_flash_t fpag_allow(fpag_flash_t c, logic rwp, logic lhp);
    fpag_flash_t r;
    r = c;
    if (c.info) begin
      if (c.addr[FPAG_PAGE_HI:FPAG_PAGE_LO] != FPAG_INFO_OPEN) begin
        r.prog   = 1'b0;
        r.read   = 1'b0;
        r.perase = 1'b0;
      end
      if (!(rwp && lhp)) begin
        r.read   = 1'b0;
        r.perase = 1'b0;
      end
    end else if (!rwp) begin
      r.prog   = 1'b0;
      r.read   = 1'b0;
      r.perase = 1'b0;
    end else if (!lhp && !c.addr[FPAG_ADDR_W-1]) begin
      r.prog   = 1'b0;
      r.read   = 1'b0;
      r.perase = 1'b0;
    end
    return r;
  endfunction : fpag_allow

endpackage : fpag_pkg

/* logic/fpag_tx_holdoff.sv */
// Transmit holdoff timer for the single-pin link
`timescale 1ns/1ps
module fpag_tx_holdoff
  import fpag_pkg::*;
#(
  parameter int BIT_CYCLES = 40
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Link activity
  input  wire logic rx_busy,
  input  wire logic char_end,
  // Permission to start a character
  output logic      tx_ok
);

  localparam int          HALF_BIT = (BIT_CYCLES / 2 < 1) ? 1 : BIT_CYCLES / 2;
  localparam logic [15:0] HALF_CNT = 16'(HALF_BIT);

  logic [15:0] gap_cnt;

  // Half-bit gap after every stop bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_cnt <= 16'h0000;
    end else if (char_end) begin
      gap_cnt <= HALF_CNT;
    end else if (gap_cnt != 16'h0000) begin
      gap_cnt <= gap_cnt - 16'h0001;
    end
  end

  // No start during gap or reception
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ok <= 1'b0;
    end else begin
      tx_ok <= !char_end && gap_cnt <= 16'h0001 && !rx_busy;
    end
  end

  a_tx_gap: assert property (@(posedge clk) disable iff (reset) char_end |=> !tx_ok [*2])
    else $error("transmit allowed inside stop-bit gap");
  a_tx_rx: assert property (@(posedge clk) disable iff (reset) rx_busy |=> !tx_ok)
    else $error("transmit allowed during reception");

endmodule : fpag_tx_holdoff

/* logic/fpag_gate.sv */
// Flash program access gate: command filter, flash controller and bypass port
`timescale 1ns/1ps
module fpag_gate
  import fpag_pkg::*;
#(
  parameter int         OP_CYCLES  = 16,
  parameter int         BIT_CYCLES = 40,
  parameter logic [7:0] REVISION   = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Decoded link commands and answers
  input  wire logic        cmd_valid,
  input  wire fpag_cmd_t   cmd,
  input  wire logic        rx_busy,
  input  wire logic        char_end,
  output logic             tx_start,
  output logic [7:0]       rsp_byte,
  output logic             cmd_reject,
  // Register file port, flash bank
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Processor flash write
  input  wire logic        cpu_req,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic             cpu_clk_stop,
  // Option bits, 1 is unprotected
  input  wire logic        flash_rw_protect_bit,
  input  wire logic        lower_half_protect_bit,
  // Bypass pins and array
  input  wire fpag_flash_t bp_pins,
  input  wire logic [7:0]  flash_rdata,
  output logic [7:0]       bp_rdata,
  output fpag_flash_t      flash_ctl
);

  localparam logic [15:0] OP_LOAD = 16'(OP_CYCLES - 1);

  fpag_state_t  state;
  fpag_state_t  next_state;
  logic [7:0]   icp_ctrl;
  logic         bypass_en;
  logic         prot_cleared;
  logic [7:0]   page_select_reg;
  logic [7:0]   sector_lock_reg;
  logic [15:0]  op_cnt;
  logic [15:0]  op_addr;
  logic [7:0]   op_data;
  logic         rsp_pend;
  logic         tx_ok;
  fpag_flash_t  bp_s1;
  fpag_flash_t  bp_s2;
  logic         fcm;
  logic         cmd_ok;
  logic         icp_wr;
  logic         wr_fcmd;
  logic         wr_page;
  logic [7:0]   wr_data;
  logic         rwp_eff;
  logic         lhp_eff;
  logic         page_match;
  logic         sec_open;
  logic         prog_go;
  logic         perase_go;
  fpag_flash_t  prog_chk;
  fpag_flash_t  erase_chk;
  fpag_flash_t  bp_gated;

  // Command filter by mode
  assign fcm = icp_ctrl[FPAG_FCM_BIT];
  always_comb begin
    unique case (cmd.code)
      FPAG_CMD_REV, FPAG_CMD_STAT,
      FPAG_CMD_WCTL, FPAG_CMD_RCTL: cmd_ok = 1'b1;
      FPAG_CMD_WFC:                 cmd_ok = fcm;
      FPAG_CMD_WTEST:               cmd_ok = 1'b1;
      default:                      cmd_ok = 1'b0;
    endcase
  end

  // Flash register writes from the link or the register port
  assign icp_wr  = cmd_valid && cmd_ok && cmd.code == FPAG_CMD_WFC;
  assign wr_data = icp_wr ? cmd.data : reg_wdata;
  assign wr_fcmd = icp_wr ? cmd.addr == FPAG_REG_FCMD
                          : (reg_wr && !bypass_en && reg_addr == FPAG_REG_FCMD);
  assign wr_page = icp_wr ? cmd.addr == FPAG_REG_PAGE
                          : (reg_wr && !bypass_en && reg_addr == FPAG_REG_PAGE);

  // Protection, lifted as a bypass mass erase starts or as a controller mass erase ends
  assign rwp_eff = flash_rw_protect_bit || prot_cleared;
  assign lhp_eff = lower_half_protect_bit || prot_cleared;

  // Controller access checks
  assign page_match = cpu_addr[FPAG_PAGE_HI:FPAG_PAGE_LO] == page_select_reg[6:0];
  assign sec_open   = page_select_reg[FPAG_INFO_BIT] ||
                      !sector_lock_reg[page_select_reg[6:4]];
  always_comb begin
    prog_chk        = '0;
    prog_chk.prog   = 1'b1;
    prog_chk.info   = page_select_reg[FPAG_INFO_BIT];
    prog_chk.addr   = cpu_addr;
    erase_chk       = '0;
    erase_chk.perase = 1'b1;
    erase_chk.info  = page_select_reg[FPAG_INFO_BIT];
    erase_chk.addr  = {page_select_reg[6:0], FPAG_PAGE_BASE};
    prog_chk        = fpag_allow(prog_chk, rwp_eff, lhp_eff);
    erase_chk       = fpag_allow(erase_chk, rwp_eff, lhp_eff);
  end
  assign prog_go   = cpu_req && !bypass_en && page_match && sec_open && prog_chk.prog;
  assign perase_go = wr_fcmd && wr_data == FPAG_FC_PERASE && sec_open && erase_chk.perase;

  // Controller state sequence
  always_comb begin
    next_state = state;
    unique case (state)
      FS_LOCKED: begin
        if (wr_fcmd && wr_data == FPAG_FC_UNLOCK1) begin
          next_state = FS_UNLK1;
        end else if (wr_fcmd && wr_data == FPAG_FC_SECSEL) begin
          next_state = FS_SECSEL;
        end
      end
      FS_UNLK1: begin
        if (wr_fcmd) begin
          next_state = (wr_data == FPAG_FC_UNLOCK2) ? FS_UNLK2 : FS_LOCKED;
        end
      end
      FS_UNLK2: begin
        next_state = FS_UNLOCKED;
      end
      FS_UNLOCKED: begin
        if (wr_fcmd && wr_data == FPAG_FC_LOCK) begin
          next_state = FS_LOCKED;
        end else if (wr_fcmd && wr_data == FPAG_FC_MERASE) begin
          next_state = FS_MERASE;
        end else if (perase_go) begin
          next_state = FS_PERASE;
        end else if (prog_go) begin
          next_state = FS_PROG;
        end
      end
      FS_SECSEL: begin
        if (wr_fcmd || wr_page) begin
          next_state = FS_LOCKED;
        end
      end
      FS_PROG, FS_PERASE, FS_MERASE: begin
        if (op_cnt == 16'h0000) begin
          next_state = FS_UNLOCKED;
        end
      end
      default: next_state = FS_LOCKED;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= FS_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  // Operation timer and captured target
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_cnt  <= 16'h0000;
      op_addr <= 16'h0000;
      op_data <= FPAG_RESET_BYTE;
    end else if (state == FS_UNLOCKED && next_state != FS_UNLOCKED && next_state != FS_LOCKED) begin
      op_cnt  <= OP_LOAD;
      op_addr <= cpu_addr;
      op_data <= cpu_wdata;
    end else if (op_cnt != 16'h0000) begin
      op_cnt  <= op_cnt - 16'h0001;
    end
  end

  // Shared page select / sector lock address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      page_select_reg <= FPAG_RESET_BYTE;
      sector_lock_reg <= FPAG_RESET_BYTE;
    end else if (wr_page && state == FS_SECSEL) begin
      sector_lock_reg <= sector_lock_reg | wr_data;
    end else if (wr_page) begin
      page_select_reg <= wr_data;
    end
  end

  // Link control register, bypass enable and answers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      icp_ctrl   <= FPAG_RESET_BYTE;
      bypass_en  <= 1'b0;
      rsp_pend   <= 1'b0;
      rsp_byte   <= FPAG_RESET_BYTE;
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= cmd_valid && !cmd_ok;
      if (cmd_valid && cmd_ok) begin
        unique case (cmd.code)
          FPAG_CMD_REV: begin
            rsp_byte <= REVISION;
            rsp_pend <= 1'b1;
          end
          FPAG_CMD_STAT: begin
            rsp_byte <= {6'h00, bypass_en, fcm};
            rsp_pend <= 1'b1;
          end
          FPAG_CMD_RCTL: begin
            rsp_byte <= icp_ctrl;
            rsp_pend <= 1'b1;
          end
          FPAG_CMD_WCTL: icp_ctrl <= cmd.data;
          FPAG_CMD_WTEST: bypass_en <= bypass_en || cmd.data == FPAG_TEST_BYPASS;
          default: ;
        endcase
      end else if (rsp_pend && tx_ok) begin
        rsp_pend <= 1'b0;
      end
    end
  end

  // Answer start pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= rsp_pend && tx_ok && !(cmd_valid && cmd_ok);
    end
  end

  fpag_tx_holdoff #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_holdoff (
    .clk      (clk),
    .reset    (reset),
    .rx_busy  (rx_busy),
    .char_end (char_end),
    .tx_ok    (tx_ok)
  );

  // Processor clock stop in bypass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_clk_stop <= 1'b0;
    end else begin
      cpu_clk_stop <= bypass_en;
    end
  end

  // Bypass pins through two flip-flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bp_s1 <= '0;
      bp_s2 <= '0;
    end else begin
      bp_s1 <= bp_pins;
      bp_s2 <= bp_s1;
    end
  end

  assign bp_gated = fpag_allow(bp_s2, rwp_eff, lhp_eff);

  // Mass erase lifts protection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prot_cleared <= 1'b0;
    end else if ((bypass_en && bp_s2.merase) || (state == FS_MERASE && op_cnt == 16'h0000)) begin
      prot_cleared <= 1'b1;
    end
  end

  // Flash array controls
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_ctl <= '0;
    end else if (bypass_en) begin
      flash_ctl <= bp_gated;
    end else begin
      flash_ctl        <= '0;
      flash_ctl.info   <= page_select_reg[FPAG_INFO_BIT];
      flash_ctl.prog   <= state == FS_PROG;
      flash_ctl.perase <= state == FS_PERASE;
      flash_ctl.merase <= state == FS_MERASE;
      flash_ctl.wdata  <= op_data;
      flash_ctl.addr   <= (state == FS_PERASE) ? {page_select_reg[6:0], FPAG_PAGE_BASE} : op_addr;
    end
  end

  // Bypass read data, zero when the read is refused
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bp_rdata <= FPAG_RESET_BYTE;
    end else begin
      bp_rdata <= (bypass_en && flash_ctl.read) ? flash_rdata : FPAG_RESET_BYTE;
    end
  end

  // Register port read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= FPAG_RESET_BYTE;
    end else if (reg_rd && reg_addr == FPAG_REG_FCMD) begin
      reg_rdata <= {2'b00, fpag_status(state)};
    end else if (reg_rd && reg_addr == FPAG_REG_PAGE) begin
      reg_rdata <= page_select_reg;
    end else begin
      reg_rdata <= FPAG_RESET_BYTE;
    end
  end

  a_outside_fcm: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !fcm && cmd.code == FPAG_CMD_WFC && !reg_wr && !cpu_req &&
    !(state inside {FS_UNLK2, FS_PROG, FS_PERASE, FS_MERASE}) |=> cmd_reject && $stable(state))
    else $error("flash write command taken outside flash control mode");
  a_status_read: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == FPAG_REG_FCMD |=> reg_rdata == {2'b00, fpag_status($past(state))})
    else $error("status read does not match controller state");
  a_unlock_seq: assert property (@(posedge clk) disable iff (reset)
    state == FS_LOCKED && wr_fcmd && wr_data == FPAG_FC_UNLOCK1 ##1
    wr_fcmd && wr_data == FPAG_FC_UNLOCK2 |=> fpag_status(state) == FPAG_ST_UNLK2 ##1
    fpag_status(state) == FPAG_ST_UNLOCKED)
    else $error("unlock sequence did not reach unlocked");
  a_sector_sel: assert property (@(posedge clk) disable iff (reset)
    state == FS_SECSEL && wr_page && !wr_fcmd |=> sector_lock_reg == ($past(sector_lock_reg) | $past(wr_data))
    && page_select_reg == $past(page_select_reg))
    else $error("shared address write went to the wrong register");
  a_page_match: assert property (@(posedge clk) disable iff (reset)
    state == FS_UNLOCKED && next_state == FS_PROG |-> cpu_addr[FPAG_PAGE_HI:FPAG_PAGE_LO] == page_select_reg[6:0])
    else $error("byte program started on a foreign page");
  a_op_status: assert property (@(posedge clk) disable iff (reset)
    state == FS_UNLOCKED && next_state == FS_PERASE |=> fpag_status(state) == FPAG_ST_PERASE ##1 flash_ctl.perase)
    else $error("page erase not shown in status");
  a_clk_stop: assert property (@(posedge clk) disable iff (reset)
    bypass_en |=> cpu_clk_stop && state != FS_PROG || $past(state) == FS_PROG)
    else $error("processor clock runs in bypass");
  a_rw_deny: assert property (@(posedge clk) disable iff (reset)
    bypass_en && !rwp_eff && !bp_s2.info |=> !(flash_ctl.prog || flash_ctl.read || flash_ctl.perase))
    else $error("protected main memory reachable in bypass");
  a_upper_half: assert property (@(posedge clk) disable iff (reset)
    bypass_en && rwp_eff && !lhp_eff && !bp_s2.info && (bp_s2.prog || bp_s2.read || bp_s2.perase)
    |=> flash_ctl.addr[FPAG_ADDR_W-1] || !(flash_ctl.prog || flash_ctl.read || flash_ctl.perase))
    else $error("lower half reachable in bypass");
  a_info_page: assert property (@(posedge clk) disable iff (reset)
    bypass_en && bp_s2.info && bp_s2.addr[FPAG_PAGE_HI:FPAG_PAGE_LO] != FPAG_INFO_OPEN
    |=> !(flash_ctl.prog || flash_ctl.read || flash_ctl.perase))
    else $error("closed info page reachable in bypass");

  c_unlocked: cover property (@(posedge clk) disable iff (reset) state == FS_UNLOCKED);
  c_program: cover property (@(posedge clk) disable iff (reset) flash_ctl.prog && !bypass_en);
  c_bypass: cover property (@(posedge clk) disable iff (reset) bypass_en && bp_s2.merase);
  c_answer: cover property (@(posedge clk) disable iff (reset) tx_start);

endmodule : fpag_gate

/* sim/fpag_host_model.sv */
// Host programmer model on the decoded single-pin link
`timescale 1ns/1ps
module fpag_host_model
  import fpag_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Link towards the gate
  output logic      cmd_valid,
  output fpag_cmd_t cmd,
  output logic      rx_busy,
  output logic      char_end
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
    rx_busy   = 1'b0;
    char_end  = 1'b0;
  end

  // One character received, then the decoded command pulses
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk);
    rx_busy <= 1'b1;
    @(posedge clk);
    rx_busy   <= 1'b0;
    char_end  <= 1'b1;
    cmd_valid <= 1'b1;
    cmd       <= '{code: code, addr: 8'h00, data: data};
    @(posedge clk);
    char_end  <= 1'b0;
    cmd_valid <= 1'b0;
    cmd       <= '{code: ~code, addr: 8'hFF, data: ~data}; // Stale bus shows no old value
  endtask : send
endmodule : fpag_host_model

/* sim/fpag_gate_tb_top.sv */
// Self-checking bench for the flash program access gate
`timescale 1ns/1ps
module fpag_gate_tb_top;
  import fpag_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid, rx_busy, char_end, tx_start, cmd_reject;
  fpag_cmd_t   cmd;
  logic [7:0]  rsp_byte, reg_rdata, bp_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        cpu_req = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        cpu_clk_stop;
  fpag_flash_t bp_pins = '0;
  logic        rwp = 1'b1;
  logic        lhp = 1'b0;
  fpag_flash_t flash_ctl;
  int          error_cnt = 0;
  int          num_checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  fpag_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .rx_busy(rx_busy), .char_end(char_end));

  fpag_gate #(.OP_CYCLES(2), .BIT_CYCLES(4)) DUT (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .rx_busy(rx_busy), .char_end(char_end),
    .tx_start(tx_start), .rsp_byte(rsp_byte), .cmd_reject(cmd_reject), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_clk_stop(cpu_clk_stop),
    .flash_rw_protect_bit(rwp), .lower_half_protect_bit(lhp), .bp_pins(bp_pins),
    .flash_rdata(8'hA5), .bp_rdata(bp_rdata), .flash_ctl(flash_ctl));

  // Compare and count
  task automatic chk(input string name, input logic [28:0] exp, input logic [28:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {21'h0, exp}, {21'h0, reg_rdata});
  endtask : reg_read

  // One processor byte program request
  task automatic cpu_program(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_req   <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask : cpu_program

  // Unlock walk, page-matched program and an erase in flight
  task automatic test_unlock;
    reg_read(FPAG_REG_FCMD, 8'h00);
    reg_write(FPAG_REG_FCMD, FPAG_FC_UNLOCK1);
    reg_read(FPAG_REG_FCMD, 8'h01);
    reg_write(FPAG_REG_FCMD, FPAG_FC_UNLOCK2);
    repeat (3) @(posedge clk);
    reg_read(FPAG_REG_FCMD, 8'h03);
    reg_read(8'h77, 8'h00);
    // Upper half page, clear of the lower-half protect
    reg_write(FPAG_REG_PAGE, 8'h40);
    cpu_program(16'h0012, 8'h3C);
    reg_read(FPAG_REG_FCMD, 8'h03);
    cpu_program(16'h8012, 8'h3C);
    reg_read(FPAG_REG_FCMD, 8'h08);
    chk("ctl_prog", 29'h1, {28'h0, flash_ctl.prog});
    chk("ctl_prog_target", {5'h00, 16'h8012, 8'h3C}, {5'h00, flash_ctl.addr, flash_ctl.wdata});
    reg_write(FPAG_REG_FCMD, FPAG_FC_PERASE);
    reg_read(FPAG_REG_FCMD, 8'h10);
    chk("ctl_perase", 29'h1, {28'h0, flash_ctl.perase});
    chk("ctl_perase_addr", 29'h8000, {13'h0, flash_ctl.addr});
    repeat (6) @(posedge clk);
  endtask : test_unlock

  // Shared address steering to the sector lock
  task automatic test_secsel;
    reg_write(FPAG_REG_FCMD, FPAG_FC_LOCK);
    reg_read(FPAG_REG_FCMD, 8'h00);
    reg_write(FPAG_REG_FCMD, FPAG_FC_SECSEL);
    reg_read(FPAG_REG_FCMD, 8'h04);
    reg_write(FPAG_REG_PAGE, 8'h01);
    reg_read(FPAG_REG_FCMD, 8'h00);
    reg_read(FPAG_REG_PAGE, 8'h40);
  endtask : test_secsel

  // Command filter outside and inside flash control mode
  task automatic test_link;
    logic [7:0] codes [6] = '{8'h01, 8'h03, 8'h06, 8'h07, FPAG_CMD_WFC, FPAG_CMD_REV};
    foreach (codes[i]) begin
      host.send(codes[i], 8'h00);
      #1 chk("cmd_reject", {28'h0, codes[i] != FPAG_CMD_REV}, {28'h0, cmd_reject});
    end
    chk("rsp_byte", 29'h5A, {21'h0, rsp_byte});
    repeat (3) @(posedge clk);
    #1 chk("tx_start", 29'h1, {28'h0, tx_start});
    @(posedge clk);
    #1 chk("tx_start_end", 29'h0, {28'h0, tx_start});
    host.send(FPAG_CMD_WCTL, 8'h81);
    host.send(FPAG_CMD_RCTL, 8'h00);
    #1 chk("rsp_ctrl", 29'h81, {21'h0, rsp_byte});
    host.send(FPAG_CMD_WFC, 8'h00);
    #1 chk("fcm_reject", 29'h0, {28'h0, cmd_reject});
    host.send(FPAG_CMD_STAT, 8'h00);
    #1 chk("rsp_stat", 29'h01, {21'h0, rsp_byte});
  endtask : test_link

  // Bypass enable, protect narrowing, mass erase and info page
  task automatic test_bypass;
    host.send(FPAG_CMD_WTEST, FPAG_TEST_BYPASS);
    repeat (2) @(posedge clk);
    chk("cpu_clk_stop", 29'h1, {28'h0, cpu_clk_stop});
    cpu_req  <= 1'b1;
    cpu_addr <= 16'h8012;
    bp_pins  <= '{prog: 1'b0, read: 1'b1, perase: 1'b0, merase: 1'b0, info: 1'b0, addr: 16'h0100, wdata: 8'h00};
    @(posedge clk);
    cpu_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk("ctl_prog", 29'h0, {28'h0, flash_ctl.prog});
    chk("ctl_read_low", 29'h0, {28'h0, flash_ctl.read});
    chk("bp_rdata_low", 29'h0, {21'h0, bp_rdata});
    bp_pins.addr <= 16'h8100;
    rwp          <= 1'b0;
    repeat (5) @(posedge clk);
    chk("ctl_read_rwp", 29'h0, {28'h0, flash_ctl.read});
    rwp <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ctl_read_high", 29'h1, {28'h0, flash_ctl.read});
    chk("ctl_addr", 29'h8100, {13'h0, flash_ctl.addr});
    chk("bp_rdata_high", 29'hA5, {21'h0, bp_rdata});
    bp_pins.read   <= 1'b0;
    bp_pins.merase <= 1'b1;
    rwp            <= 1'b0;
    repeat (5) @(posedge clk);
    chk("ctl_merase", 29'h1, {28'h0, flash_ctl.merase});
    bp_pins <= '{prog: 1'b0, read: 1'b1, perase: 1'b0, merase: 1'b0, info: 1'b0, addr: 16'h0100, wdata: 8'h00};
    repeat (5) @(posedge clk);
    chk("ctl_read_erased", 29'h1, {28'h0, flash_ctl.read});
    bp_pins.info <= 1'b1;
    bp_pins.addr <= 16'h0600;
    repeat (5) @(posedge clk);
    chk("ctl_info_open", 29'h1, {28'h0, flash_ctl.read});
    bp_pins.addr <= 16'h0800;
    repeat (5) @(posedge clk);
    chk("ctl_info_closed", 29'h0, {28'h0, flash_ctl.read});
  endtask : test_bypass

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    test_unlock();
    test_secsel();
    test_link();
    test_bypass();
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule : fpag_gate_tb_top
